/* File: logic/rfcrc_pkg.sv */
`default_nettype none
package rfcrc_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] IDX_CTRL = 8'h28;
	localparam logic [7:0] IDX_STATUS = 8'h29;
	localparam logic [7:0] IDX_TX_CRC_CONFIG = 8'h2c;
	localparam logic [7:0] IDX_RX_CRC_CONFIG = 8'h2d;
	localparam logic [7:0] IDX_TX_BIT_COUNT_CONFIG = 8'h2e;
	localparam logic [7:0] IDX_TX_PULSE_WIDTH = 8'h2f;
	localparam logic [7:0] RST_REG = 8'h00;
	// crc config fields, same layout for transmit and receive except bit 7, which is receive only
	localparam int CRC_EN_POS = 0;
	localparam int CRC_COMPLEMENT_POS = 1;
	localparam int CRC_KIND_LSB = 2;
	localparam int CRC_PRESET_SEL_LSB = 4;
	localparam int RX_CRC_TO_FIFO_POS = 7;
	localparam logic [7:0] TX_CRC_CONFIG_MASK = 8'h7f;
	// tx bit count config fields
	localparam int FINAL_BYTE_BIT_COUNT_LSB = 0;
	localparam int PAYLOAD_SEND_EN_POS = 3;
	localparam int ETU_GRID_ALIGN_POS = 4;
	localparam logic [7:0] TX_BIT_COUNT_CONFIG_MASK = 8'h1f;
	// ctrl fields; start reads back as zero
	localparam int CTRL_START_POS = 0;
	localparam int CTRL_MILLER_POS = 1;
	localparam int PULSE_START_POS_SEL_LSB = 2;
	localparam logic [7:0] CTRL_MASK = 8'h0e;
	// status fields
	localparam int STAT_TX_BUSY_POS = 0;
	localparam int STAT_RX_BUSY_POS = 1;
	localparam int STAT_CRC_ERR_POS = 2;
	localparam int STAT_CRC_OK_POS = 3;
	// bit timing in carrier clocks
	localparam int ETU_CARRIERS = 128;
	localparam logic [6:0] ETU_LAST = 7'(ETU_CARRIERS - 1);
	localparam logic [6:0] ETU_HALF = 7'(ETU_CARRIERS / 2);
	localparam logic [6:0] PULSE_POS_STEP = 7'(ETU_CARRIERS / 8);
	// reflected polynomials, lsb first
	localparam logic [15:0] CRC16_POLY = 16'h8408;
	localparam logic [15:0] CRC8_POLY = 16'h00b8;
	localparam logic [15:0] CRC5_POLY = 16'h0012;
	localparam logic [2:0] PRESET_SEL_USER = 3'h6;
	// preset tables, index 7 first; undefined codes give zero
	localparam logic [7:0][15:0] PRESET16 = {16'hffff, 16'h0000, 16'h0000, 16'h0000,
		16'hfffe, 16'ha671, 16'h6363, 16'h0000};
	localparam logic [7:0][7:0] PRESET8 = {8'hff, 8'h00, 8'h00, 8'h00,
		8'hfd, 8'hbf, 8'h12, 8'h00};
	localparam logic [7:0][7:0] PRESET5 = {8'h1f, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h12, 8'h00};

	typedef enum logic [1:0] {
		CRC_KIND_5 = 2'h0,
		CRC_KIND_8 = 2'h1,
		CRC_KIND_16 = 2'h2,
		CRC_KIND_RSV = 2'h3
	} rfcrc_kind_type;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_GRID = 3'b001,
		TX_DATA = 3'b011,
		TX_CRC = 3'b010,
		TX_SYM = 3'b110
	} rfcrc_tx_state_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_RECV = 2'b01,
		RX_FLUSH = 2'b11
	} rfcrc_rx_state_type;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} rfcrc_tx_byte_type;

	typedef struct packed {
		logic is_crc;
		logic [7:0] data;
	} rfcrc_rx_byte_type;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [7:0] tx_crc_config;
		logic [7:0] rx_crc_config;
		logic [7:0] tx_bit_count_config;
		logic [7:0] tx_pulse_width;
		logic [7:0] ctrl;
		logic crc_err;
		logic crc_ok;
		rfcrc_tx_state_type tx_st;
		logic tx_busy;
		logic tx_ready;
		logic [15:0] tx_crc;
		logic [15:0] sh;
		logic [4:0] sh_n;
		rfcrc_tx_byte_type nxt;
		logic nxt_v;
		logic last_seen;
		logic run;
		logic cur_bit;
		logic prev_bit;
		logic strobe;
		logic need_pulse;
		logic pulse;
		logic mod;
		logic [6:0] bit_cnt;
		logic [6:0] grid_cnt;
		logic [6:0] pulse_at;
		logic [7:0] pulse_cnt;
		rfcrc_rx_state_type rx_st;
		logic rx_busy;
		logic [15:0] rx_crc;
		logic [15:0] win;
		logic [4:0] fill;
		logic [7:0] rx_byte;
		logic [3:0] rx_bcnt;
		logic [1:0] flush;
		rfcrc_rx_byte_type rx_out;
		logic rx_out_v;
	} rfcrc_state_type;

	function automatic logic [4:0] rfcrc_width(input rfcrc_kind_type k);
		unique case (k)
			CRC_KIND_5: rfcrc_width = 5'd5;
			CRC_KIND_8: rfcrc_width = 5'd8;
			CRC_KIND_16: rfcrc_width = 5'd16;
			CRC_KIND_RSV: rfcrc_width = 5'd0;
		endcase
	endfunction : rfcrc_width

	function automatic logic [15:0] rfcrc_mask(input rfcrc_kind_type k);
		unique case (k)
			CRC_KIND_5: rfcrc_mask = 16'h001f;
			CRC_KIND_8: rfcrc_mask = 16'h00ff;
			CRC_KIND_16: rfcrc_mask = 16'hffff;
			CRC_KIND_RSV: rfcrc_mask = 16'h0000;
		endcase
	endfunction : rfcrc_mask

	function automatic logic [15:0] rfcrc_step(input logic [15:0] crc, input logic b,
		input rfcrc_kind_type k);
		logic [15:0] poly;
		unique case (k)
			CRC_KIND_5: poly = CRC5_POLY;
			CRC_KIND_8: poly = CRC8_POLY;
			CRC_KIND_16: poly = CRC16_POLY;
			CRC_KIND_RSV: poly = 16'h0000;
		endcase
		rfcrc_step = (crc >> 1) ^ ((crc[0] ^ b) ? poly : 16'h0000);
	endfunction : rfcrc_step

	function automatic logic [15:0] rfcrc_preset(input rfcrc_kind_type k, input logic [2:0] sel,
		input logic [15:0] user);
		logic [15:0] p;
		unique case (k)
			CRC_KIND_5: p = {8'h00, PRESET5[sel]};
			CRC_KIND_8: p = {8'h00, PRESET8[sel]};
			CRC_KIND_16: p = PRESET16[sel];
			CRC_KIND_RSV: p = 16'h0000;
		endcase
		if (sel == PRESET_SEL_USER) begin
			p = user;
		end
		rfcrc_preset = p & rfcrc_mask(k);
	endfunction : rfcrc_preset
endpackage : rfcrc_pkg
`default_nettype wire

/* File: logic/rfcrc_top.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rfcrc_top
	import rfcrc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// configuration storage
	input wire logic [15:0] user_preset_i,
	// transmit byte stream
	input wire rfcrc_tx_byte_type tx_byte_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// transmit line side
	input wire logic carrier_tick_i,
	output logic tx_bit_o,
	output logic tx_bit_strobe_o,
	output logic tx_mod_o,
	output logic tx_busy_o,
	// receive bit stream
	input wire logic rx_bit_i,
	input wire logic rx_bit_valid_i,
	input wire logic rx_frame_end_i,
	// receive fifo side
	output rfcrc_rx_byte_type rx_byte_o,
	output logic rx_byte_valid_o,
	output logic rx_busy_o,
	output logic crc_err_o
);
	rfcrc_state_type q;
	rfcrc_state_type d;

	rfcrc_kind_type tx_kind;
	rfcrc_kind_type rx_kind;
	logic [4:0] tx_w;
	logic [4:0] rx_w;
	logic [15:0] rx_preset;
	logic [15:0] rx_got;
	logic [15:0] rx_exp;
	logic [15:0] tx_out;
	logic [4:0] load_n;
	logic access;
	logic start;
	logic tick_end;
	logic boundary;
	logic has_bit;
	logic nb;
	logic dropped;
	logic [15:0] rx_base;
	logic [2:0] last_cfg;

	always_comb begin
		d = q;
		tx_kind = rfcrc_kind_type'(q.tx_crc_config[CRC_KIND_LSB +: 2]);
		rx_kind = rfcrc_kind_type'(q.rx_crc_config[CRC_KIND_LSB +: 2]);
		tx_w = rfcrc_width(tx_kind);
		rx_w = rfcrc_width(rx_kind);
		rx_preset = rfcrc_preset(rx_kind, q.rx_crc_config[CRC_PRESET_SEL_LSB +: 3],
			user_preset_i);
		rx_got = (q.win >> (5'd16 - rx_w)) & rfcrc_mask(rx_kind);
		rx_exp = q.rx_crc ^ (q.rx_crc_config[CRC_COMPLEMENT_POS] ?
			rfcrc_mask(rx_kind) : 16'h0000);
		tx_out = q.tx_crc ^ (q.tx_crc_config[CRC_COMPLEMENT_POS] ?
			rfcrc_mask(tx_kind) : 16'h0000);
		last_cfg = q.tx_bit_count_config[FINAL_BYTE_BIT_COUNT_LSB +: 3];
		load_n = (q.nxt.last && last_cfg != 3'h0) ? {2'b00, last_cfg} : 5'd8;
		access = cyc_i & stb_i & ~q.ack;
		start = 1'b0;
		has_bit = 1'b0;
		nb = 1'b0;
		dropped = 1'b0;
		rx_base = 16'h0000;
		d.ack = access;
		d.strobe = 1'b0;
		d.rx_out_v = 1'b0;

		// register access
		if (access) begin
			d.rdat = 32'h0000_0000;
			unique case (adr_i)
				{IDX_TX_CRC_CONFIG[5:0], 2'b00}: d.rdat[7:0] = q.tx_crc_config;
				{IDX_RX_CRC_CONFIG[5:0], 2'b00}: d.rdat[7:0] = q.rx_crc_config;
				{IDX_TX_BIT_COUNT_CONFIG[5:0], 2'b00}: d.rdat[7:0] = q.tx_bit_count_config;
				{IDX_TX_PULSE_WIDTH[5:0], 2'b00}: d.rdat[7:0] = q.tx_pulse_width;
				{IDX_CTRL[5:0], 2'b00}: d.rdat[7:0] = q.ctrl;
				{IDX_STATUS[5:0], 2'b00}: begin
					d.rdat[STAT_TX_BUSY_POS] = q.tx_busy;
					d.rdat[STAT_RX_BUSY_POS] = q.rx_busy;
					d.rdat[STAT_CRC_ERR_POS] = q.crc_err;
					d.rdat[STAT_CRC_OK_POS] = q.crc_ok;
				end
				default: d.rdat = 32'h0000_0000;
			endcase
			if (we_i && sel_i[0]) begin
				unique case (adr_i)
					{IDX_TX_CRC_CONFIG[5:0], 2'b00}: d.tx_crc_config = dat_i[7:0] & TX_CRC_CONFIG_MASK;
					{IDX_RX_CRC_CONFIG[5:0], 2'b00}: d.rx_crc_config = dat_i[7:0];
					{IDX_TX_BIT_COUNT_CONFIG[5:0], 2'b00}: d.tx_bit_count_config =
						dat_i[7:0] & TX_BIT_COUNT_CONFIG_MASK;
					{IDX_TX_PULSE_WIDTH[5:0], 2'b00}: d.tx_pulse_width = dat_i[7:0];
					{IDX_CTRL[5:0], 2'b00}: begin
						d.ctrl = dat_i[7:0] & CTRL_MASK;
						start = dat_i[CTRL_START_POS];
					end
					{IDX_STATUS[5:0], 2'b00}: begin
						if (dat_i[STAT_CRC_ERR_POS]) begin
							d.crc_err = 1'b0;
						end
					end
					default: d.ctrl = q.ctrl;
				endcase
			end
		end

		// etu grid and bit timing on carrier clocks
		tick_end = carrier_tick_i && q.run && q.bit_cnt == ETU_LAST;
		if (carrier_tick_i) begin
			d.grid_cnt = (q.grid_cnt == ETU_LAST) ? 7'd0 : q.grid_cnt + 7'd1;
		end
		if (carrier_tick_i && q.run) begin
			d.bit_cnt = q.bit_cnt + 7'd1;
			if (q.pulse) begin
				if (q.pulse_cnt == 8'h00 || q.bit_cnt == ETU_LAST) begin
					d.pulse = 1'b0;
				end else begin
					d.pulse_cnt = q.pulse_cnt - 8'h01;
				end
			end else if (q.need_pulse && q.bit_cnt == q.pulse_at) begin
				d.pulse = 1'b1;
				d.pulse_cnt = q.tx_pulse_width;
				d.need_pulse = 1'b0;
			end
		end

		// transmit byte intake, one byte held ahead of the shifter
		if (tx_valid_i && q.tx_ready) begin
			d.nxt = tx_byte_i;
			d.nxt_v = 1'b1;
			d.last_seen = tx_byte_i.last;
		end

		// transmit sequencer
		boundary = (q.tx_st == TX_DATA || q.tx_st == TX_CRC || q.tx_st == TX_SYM) &&
			(!q.run || tick_end);
		unique case (q.tx_st)
			TX_IDLE: begin
				if (start) begin
					d.tx_crc = rfcrc_preset(tx_kind, q.tx_crc_config[CRC_PRESET_SEL_LSB +: 3],
						user_preset_i);
					d.prev_bit = 1'b0;
					d.last_seen = 1'b0;
					d.nxt_v = 1'b0;
					d.run = 1'b0;
					d.sh_n = 5'd0;
					if (q.tx_bit_count_config[ETU_GRID_ALIGN_POS]) begin
						d.tx_st = TX_GRID;
					end else if (q.tx_bit_count_config[PAYLOAD_SEND_EN_POS]) begin
						d.tx_st = TX_DATA;
					end else begin
						d.tx_st = TX_SYM;
						d.sh = 16'h0000;
						d.sh_n = 5'd1;
					end
				end
			end
			TX_GRID: begin
				if (carrier_tick_i && q.grid_cnt == ETU_LAST) begin
					if (q.tx_bit_count_config[PAYLOAD_SEND_EN_POS]) begin
						d.tx_st = TX_DATA;
					end else begin
						d.tx_st = TX_SYM;
						d.sh = 16'h0000;
						d.sh_n = 5'd1;
					end
				end
			end
			default: begin
				if (boundary) begin
					if (q.sh_n != 5'd0) begin
						has_bit = 1'b1;
						nb = q.sh[0];
						d.sh = q.sh >> 1;
						d.sh_n = q.sh_n - 5'd1;
						if (q.tx_st == TX_DATA) begin
							d.tx_crc = rfcrc_step(q.tx_crc, nb, tx_kind);
						end
					end else if (q.tx_st == TX_DATA && q.nxt_v) begin
						has_bit = 1'b1;
						nb = q.nxt.data[0];
						d.sh = {8'h00, 1'b0, q.nxt.data[7:1]};
						d.sh_n = load_n - 5'd1;
						d.nxt_v = 1'b0;
						d.tx_crc = rfcrc_step(q.tx_crc, nb, tx_kind);
					end else if (q.tx_st == TX_DATA && q.last_seen &&
						q.tx_crc_config[CRC_EN_POS] && tx_w != 5'd0) begin
						has_bit = 1'b1;
						nb = tx_out[0];
						d.sh = tx_out >> 1;
						d.sh_n = tx_w - 5'd1;
						d.tx_st = TX_CRC;
					end else if (q.tx_st != TX_DATA || q.last_seen) begin
						d.tx_st = TX_IDLE;
						d.run = 1'b0;
						d.pulse = 1'b0;
						d.need_pulse = 1'b0;
					end else begin
						d.run = 1'b0;
					end
				end
			end
		endcase

		// start of a new bit and its miller pulse plan
		if (has_bit) begin
			d.cur_bit = nb;
			d.run = 1'b1;
			d.strobe = 1'b1;
			d.bit_cnt = 7'd0;
			d.prev_bit = nb;
			d.need_pulse = q.ctrl[CTRL_MILLER_POS] &&
				(nb || !q.prev_bit || q.tx_st == TX_SYM);
			d.pulse_at = (nb && q.tx_st != TX_SYM ? ETU_HALF : 7'd0) +
				7'(q.ctrl[PULSE_START_POS_SEL_LSB +: 2]) * PULSE_POS_STEP;
		end
		d.tx_ready = (d.tx_st == TX_DATA) && !d.nxt_v && !d.last_seen;
		d.tx_busy = d.tx_st != TX_IDLE;
		d.mod = q.ctrl[CTRL_MILLER_POS] ? d.pulse : (d.run && d.cur_bit);

		// receive side
		unique case (q.rx_st)
			RX_IDLE, RX_RECV: begin
				rx_base = (q.rx_st == RX_IDLE) ? rx_preset : q.rx_crc;
				if (q.rx_st == RX_IDLE) begin
					d.rx_crc = rx_preset;
				end
				if (rx_bit_valid_i) begin
					d.rx_st = RX_RECV;
					d.win = {rx_bit_i, q.win[15:1]};
					dropped = (rx_w == 5'd0) ? rx_bit_i : rx_got[0];
					if (q.fill == rx_w) begin
						d.rx_crc = rfcrc_step(rx_base, dropped, rx_kind);
						d.rx_byte = {dropped, q.rx_byte[7:1]};
						if (q.rx_bcnt == 4'd7) begin
							d.rx_bcnt = 4'd0;
							d.rx_out = '{is_crc: 1'b0, data: {dropped, q.rx_byte[7:1]}};
							d.rx_out_v = 1'b1;
						end else begin
							d.rx_bcnt = q.rx_bcnt + 4'd1;
						end
					end else begin
						d.fill = q.fill + 5'd1;
						d.rx_crc = rx_base;
					end
				end else if (rx_frame_end_i && q.rx_st == RX_RECV) begin
					d.rx_st = RX_FLUSH;
					d.flush = 2'd0;
					d.crc_ok = (rx_w != 5'd0) && (q.fill == rx_w) && (rx_got == rx_exp);
					if (q.rx_crc_config[CRC_EN_POS] && rx_w != 5'd0 &&
						!((q.fill == rx_w) && (rx_got == rx_exp))) begin
						d.crc_err = 1'b1;
					end
				end
			end
			RX_FLUSH: begin
				d.flush = q.flush + 2'd1;
				if (q.flush == 2'd0 && q.rx_bcnt != 4'd0) begin
					d.rx_out = '{is_crc: 1'b0, data: q.rx_byte >> (4'd8 - q.rx_bcnt)};
					d.rx_out_v = 1'b1;
				end else if (q.flush == 2'd1 && q.rx_crc_config[RX_CRC_TO_FIFO_POS] &&
					rx_w != 5'd0) begin
					d.rx_out = '{is_crc: 1'b1, data: rx_got[7:0]};
					d.rx_out_v = 1'b1;
				end else if (q.flush == 2'd2 && q.rx_crc_config[RX_CRC_TO_FIFO_POS] &&
					rx_w > 5'd8) begin
					d.rx_out = '{is_crc: 1'b1, data: rx_got[15:8]};
					d.rx_out_v = 1'b1;
				end
				if (q.flush == 2'd2) begin
					d.rx_st = RX_IDLE;
					d.fill = 5'd0;
					d.rx_bcnt = 4'd0;
					d.win = 16'h0000;
				end
			end
			default: d.rx_st = RX_IDLE;
		endcase
		d.rx_busy = d.rx_st != RX_IDLE;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.tx_crc_config <= RST_REG;
			q.rx_crc_config <= RST_REG;
			q.tx_bit_count_config <= RST_REG;
			q.tx_pulse_width <= RST_REG;
			q.ctrl <= RST_REG;
			q.tx_st <= TX_IDLE;
			q.rx_st <= RX_IDLE;
		end else begin
			q <= d;
		end
	end

	assign dat_o = q.rdat;
	assign ack_o = q.ack;
	assign tx_ready_o = q.tx_ready;
	assign tx_bit_o = q.cur_bit;
	assign tx_bit_strobe_o = q.strobe;
	assign tx_mod_o = q.mod;
	assign tx_busy_o = q.tx_busy;
	assign rx_byte_o = q.rx_out;
	assign rx_byte_valid_o = q.rx_out_v;
	assign rx_busy_o = q.rx_busy;
	assign crc_err_o = q.crc_err;
endmodule : rfcrc_top
`default_nettype wire

/* File: verification/rfcrc_card.sv */
`timescale 1ns/1ps
`default_nettype none
module rfcrc_card (
	// clock
	input wire logic clk_i,
	// from the reader
	input wire logic tx_bit_i,
	input wire logic tx_bit_strobe_i,
	// to the reader
	output var logic rx_bit_o,
	output var logic rx_bit_valid_o,
	output var logic rx_frame_end_o
);
	logic [31:0] got;
	int n;
	initial begin
		rx_bit_o = 1'b0;
		rx_bit_valid_o = 1'b0;
		rx_frame_end_o = 1'b0;
		got = '0;
		n = 0;
	end
	// bits kept in arrival order
	always @(posedge clk_i) begin
		if (tx_bit_strobe_i === 1'b1) begin
			got[n] <= tx_bit_i;
			n <= n + 1;
		end
	end
	task automatic send(input logic [31:0] v, input int nb);
		for (int i = 0; i < nb; i++) begin
			@(posedge clk_i);
			rx_bit_o <= v[i];
			rx_bit_valid_o <= 1'b1;
		end
		@(posedge clk_i);
		rx_bit_valid_o <= 1'b0;
		rx_bit_o <= ~v[nb-1];
		@(posedge clk_i);
		rx_frame_end_o <= 1'b1;
		@(posedge clk_i);
		rx_frame_end_o <= 1'b0;
	endtask : send
endmodule : rfcrc_card
`default_nettype wire

/* File: verification/rfcrc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rfcrc_chk
	import rfcrc_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// line and status
	input wire logic carrier_tick_i,
	input wire logic tx_bit_o,
	input wire logic tx_bit_strobe_o,
	input wire logic tx_mod_o,
	input wire logic tx_busy_o,
	input wire logic rx_frame_end_i,
	input wire logic crc_err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	localparam logic [7:0] A_CTRL = IDX_CTRL << 2;
	localparam logic [7:0] A_STAT = IDX_STATUS << 2;
	logic req;
	logic clr;
	logic [7:0] tick_q;
	logic seen_q;
	assign req = cyc_i & stb_i & ~ack_o;
	assign clr = req & we_i & sel_i[0] & (adr_i == A_STAT) & dat_i[STAT_CRC_ERR_POS];
	// carrier ticks since the last bit strobe
	always_ff @(posedge clk_i) begin
		tick_q <= tx_bit_strobe_o ? 8'h00 : tick_q + 8'(carrier_tick_i);
		seen_q <= ~rst_i & tx_busy_o & (seen_q | tx_bit_strobe_o);
	end
	a_ack_follows_req: assert property (req |=> ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property (ack_o |-> $past(req))
		else $error("ack without request");
	a_read_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	a_start_busy: assert property (req && we_i && sel_i[0] && adr_i == A_CTRL && dat_i[0]
		&& !tx_busy_o |=> tx_busy_o)
		else $error("start did not raise busy");
	a_bit_spacing: assert property (tx_bit_strobe_o && seen_q |-> tick_q == 8'(ETU_LAST))
		else $error("bit length not one etu");
	a_bit_stands: assert property (tx_busy_o && !tx_bit_strobe_o |-> $stable(tx_bit_o))
		else $error("bit changed inside its bit time");
	a_strobe_pulse: assert property (tx_bit_strobe_o |=> !tx_bit_strobe_o)
		else $error("strobe longer than one cycle");
	a_idle_quiet: assert property (!tx_busy_o && !$past(tx_busy_o) |-> !tx_mod_o
		&& !tx_bit_strobe_o)
		else $error("line active while idle");
	a_err_sticky: assert property (crc_err_o && !clr |=> crc_err_o)
		else $error("error flag dropped without clear");
	a_err_at_end: assert property ($rose(crc_err_o) |-> $past(rx_frame_end_i))
		else $error("error flag set outside frame end");
	c_write: cover property (req && we_i);
	c_bits: cover property (tx_bit_strobe_o && seen_q);
	c_err: cover property ($rose(crc_err_o));
endmodule : rfcrc_chk
bind rfcrc_top rfcrc_chk i_rfcrc_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .dat_o, .ack_o, .carrier_tick_i, .tx_bit_o, .tx_bit_strobe_o, .tx_mod_o, .tx_busy_o,
	.rx_frame_end_i, .crc_err_o);
`default_nettype wire

/* File: verification/rfcrc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rfcrc_top_tb;
	import rfcrc_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, tx_valid_i, tx_ready_o, carrier_tick_i;
	logic tx_bit_o, tx_bit_strobe_o, tx_mod_o, tx_busy_o, rx_bit_i, rx_bit_valid_i;
	logic rx_frame_end_i, rx_byte_valid_o, rx_busy_o, crc_err_o;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o;
	logic [15:0] user_preset_i;
	rfcrc_tx_byte_type tx_byte_i;
	rfcrc_rx_byte_type rx_byte_o;
	int n_errors = 0;
	int comparisons = 0;
	int nrx = 0;
	int nmod = 0;
	logic [7:0] rx_first, q;
	logic [7:0] ra [5] = '{8'hb0, 8'hb4, 8'hb8, 8'hbc, 8'hfc};
	logic [7:0] rm [5] = '{8'h7f, 8'hff, 8'h1f, 8'hff, 8'h00};
	logic [7:0] tcfg [3] = '{8'h1b, 8'h75, 8'h1a};
	logic [7:0] tnum [3] = '{8'h0b, 8'h08, 8'h18};
	logic [7:0] td [3] = '{8'hb2, 8'ha5, 8'h3c};
	int tnb [3] = '{3, 8, 8};
	int tw [3] = '{16, 8, 0};
	logic [15:0] tpre [3] = '{16'h6363, 16'h00ff, 16'h0000};
	logic [15:0] tinv [3] = '{16'hffff, 16'h0000, 16'h0000};
	logic [7:0] rcfg [4] = '{8'he9, 8'h69, 8'h6b, 8'h68};
	logic [15:0] rx [4] = '{16'h0000, 16'h0001, 16'hffff, 16'h0001};
	int rn [4] = '{3, 1, 1, 1};
	logic [1:0] rs [4] = '{2'b10, 2'b01, 2'b10, 2'b00};

	rfcrc_top i_rfcrc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .user_preset_i, .tx_byte_i, .tx_valid_i, .tx_ready_o, .carrier_tick_i, .tx_bit_o,
		.tx_bit_strobe_o, .tx_mod_o, .tx_busy_o, .rx_bit_i, .rx_bit_valid_i, .rx_frame_end_i,
		.rx_byte_o, .rx_byte_valid_o, .rx_busy_o, .crc_err_o);
	rfcrc_card i_rfcrc_card (.clk_i, .tx_bit_i(tx_bit_o), .tx_bit_strobe_i(tx_bit_strobe_o),
		.rx_bit_o(rx_bit_i), .rx_bit_valid_o(rx_bit_valid_i), .rx_frame_end_o(rx_frame_end_i));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (rx_byte_valid_o === 1'b1) begin
			if (nrx == 0) rx_first = rx_byte_o.data;
			nrx++;
		end
	end
	// cycles with the modulation output high
	always @(posedge clk_i) begin
		if (tx_mod_o === 1'b1) nmod++;
	end

	task end_sim;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk8
	task chkbits(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chkbits
	// one classic cycle; read byte left in q
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= {24'h0, d};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (ack_o !== 1'b1) n_errors++;
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb
	// start a one byte frame and wait until it is gone
	task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] b);
		int k;
		wb(8'ha0, 1'b1, ctl);
		k = 0;
		while (tx_ready_o !== 1'b1 && k < 400) begin
			@(posedge clk_i);
			k++;
		end
		if (k == 400) n_errors++;
		tx_byte_i <= '{last: 1'b1, data: b};
		tx_valid_i <= 1'b1;
		@(posedge clk_i);
		tx_valid_i <= 1'b0;
		k = 0;
		while (tx_busy_o !== 1'b0 && k < 5000) begin
			@(posedge clk_i);
			k++;
		end
		if (k == 5000) n_errors++;
		repeat (2) @(posedge clk_i);
	endtask : tx_frame
	function automatic logic [15:0] crc_ref(input int w, input logic [15:0] c,
		input logic [31:0] v, input int nb);
		logic [15:0] p;
		p = (w == 16) ? CRC16_POLY : (w == 8) ? CRC8_POLY : CRC5_POLY;
		for (int i = 0; i < nb; i++) c = (c >> 1) ^ ((c[0] ^ v[i]) ? p : 16'h0000);
		return c;
	endfunction : crc_ref

	initial begin
		int k;
		logic [15:0] c;
		logic [31:0] e;
		{rst_i, cyc_i, stb_i, we_i, tx_valid_i} = 5'h10;
		{adr_i, sel_i, dat_i, tx_byte_i} = '0;
		user_preset_i = 16'h1234;
		carrier_tick_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wb(ra[i], 1'b0, 8'h00);
			chk8(q, 8'h00);
			wb(ra[i], 1'b1, 8'hff);
			wb(ra[i], 1'b0, 8'h00);
			chk8(q, rm[i]);
		end
		// preset, complement, append off, final bit count, grid
		for (int f = 0; f < 3; f++) begin
			i_rfcrc_card.n = 0;
			i_rfcrc_card.got = '0;
			wb(8'hb0, 1'b1, tcfg[f]);
			wb(8'hb8, 1'b1, tnum[f]);
			tx_frame(8'h01, td[f]);
			e = 32'(td[f] & 8'((1 << tnb[f]) - 1));
			c = crc_ref(tw[f], tpre[f], 32'(td[f]), tnb[f]) ^ tinv[f];
			if (tw[f] > 0) e = e | (32'(c) << tnb[f]);
			chkbits(i_rfcrc_card.got, e);
			chkbits(32'(i_rfcrc_card.n), 32'(tnb[f] + tw[f]));
		end
		// copy, user preset, complement check, check disabled
		for (int r = 0; r < 4; r++) begin
			wb(8'hb4, 1'b1, rcfg[r]);
			nrx = 0;
			c = crc_ref(16, user_preset_i, 32'h5a, 8) ^ rx[r];
			i_rfcrc_card.send({8'h00, c, 8'h5a}, 24);
			repeat (5) @(posedge clk_i);
			chkbits(32'(nrx), 32'(rn[r]));
			chk8(rx_first, 8'h5a);
			wb(8'ha4, 1'b0, 8'h00);
			chk8({6'h00, q[3:2]}, {6'h00, rs[r]});
			wb(8'ha4, 1'b1, 8'h04);
			wb(8'ha4, 1'b0, 8'h00);
			chk8(q & 8'h04, 8'h00);
		end
		// miller pulse of a single one bit, width setting 9
		wb(8'hb0, 1'b1, 8'h00);
		wb(8'hb8, 1'b1, 8'h09);
		wb(8'hbc, 1'b1, 8'h09);
		nmod = 0;
		tx_frame(8'h03, 8'h01);
		chkbits(32'(nmod), 32'h0000_000a);
		end_sim;
	end
	initial begin
		#2000000;
		n_errors++;
		end_sim;
	end
endmodule : rfcrc_top_tb
`default_nettype wire
